// >>> hw/gmq_port.sv
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "gmq_cfg.svh"

// Functional notes
// - pins form two ports: port A pins 0-31, port B pins 32-34
// - registers accept 32-bit and 16-bit reads and writes
// - each pin carries plain I/O or one of three peripheral signals
// - port A has two function select registers, port B has one (GMQ_MUX_B2 reads zero)
// - after reset every input is only synchronised, no window filter
// - window mode takes a level after 6 or 3 equal samples per pin, pins 0-15 and 32-34 only (GMQ_QSEL_A2 is not writable)
// - sample interval is set once per group of eight pins
// - each pin has a software controlled pull-up
// - any port A pin can source each external interrupt
// - any set of port A pins can wake the device
// - wake works for plain input and peripheral input pins
module gmq_port (
    // clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // pins
    input  wire logic [`GMQ_NPIN-1:0]    pin_in,
    output logic      [`GMQ_NPIN-1:0]    pin_out,
    output logic      [`GMQ_NPIN-1:0]    pin_oe,
    output logic      [`GMQ_NPIN-1:0]    pin_pullup_en,
    // peripheral side
    input  wire logic [`GMQ_NPIN-1:0]    per1_out,
    input  wire logic [`GMQ_NPIN-1:0]    per1_oe,
    input  wire logic [`GMQ_NPIN-1:0]    per2_out,
    input  wire logic [`GMQ_NPIN-1:0]    per2_oe,
    input  wire logic [`GMQ_NPIN-1:0]    per3_out,
    input  wire logic [`GMQ_NPIN-1:0]    per3_oe,
    output logic      [`GMQ_NPIN-1:0]    per_in,
    // event sources
    output logic                         external_interrupt_one,
    output logic                         external_interrupt_two,
    output logic                         external_nonmaskable_interrupt,
    output logic                         wake_request
);

    logic [31:0]              cfg_r [`GMQ_NREG];
    logic                     wr_pend_r;
    logic                     rd_wait_r;
    logic [`GMQ_IDX_W-1:0]    idx_r;
    logic [3:0]               be_r;
    logic [31:0]              hrdata_r;
    logic                     acc;
    logic                     mapped;
    logic [`GMQ_IDX_W-1:0]    acc_idx;
    logic [3:0]               acc_be;
    logic [31:0]              rd_val;
    logic [31:0]              wr_mask;
    logic [31:0]              be_bits;
    logic [2*`GMQ_NPIN-1:0]   fsel_flat;
    logic [2*`GMQ_NPIN-1:0]   qsel_flat;
    logic [`GMQ_NPIN-1:0]     dir_all;
    logic [`GMQ_NPIN-1:0]     dat_all;
    logic [`GMQ_NPIN-1:0]     qual_in;
    logic [`GMQ_NPIN-1:0]     pin_out_nxt;
    logic [`GMQ_NPIN-1:0]     pin_oe_nxt;
    logic [`GMQ_NGRP-1:0]     smp_stb;
    logic [7:0]               per_cnt_r [`GMQ_NGRP];
    logic [7:0]               period [`GMQ_NGRP];

    // writable bits per index; unmapped and reserved bits stay zero
    function automatic logic [31:0] reg_mask(
        input logic [`GMQ_IDX_W-1:0] idx
    );
        case (idx)
            `GMQ_MUX_A1, `GMQ_MUX_A2, `GMQ_QSEL_A1,
            `GMQ_CTRL_A, `GMQ_DIR_A, `GMQ_PU_A,
            `GMQ_DAT_A, `GMQ_WAKE_SEL:          reg_mask = `GMQ_MASK_FULL;
            `GMQ_MUX_B1, `GMQ_QSEL_B1:          reg_mask = `GMQ_MASK_SEL_B;
            `GMQ_CTRL_B:                        reg_mask = `GMQ_MASK_PER_B;
            `GMQ_DIR_B, `GMQ_PU_B, `GMQ_DAT_B:  reg_mask = `GMQ_MASK_PIN_B;
            `GMQ_INT1_SEL, `GMQ_INT2_SEL,
            `GMQ_NMI_SEL:                       reg_mask = `GMQ_MASK_SRC;
            default:                            reg_mask = `GMQ_MASK_NONE;
        endcase
    endfunction

    // byte lanes from size and low address bits
    function automatic logic [3:0] lanes(
        input logic [2:0] size,
        input logic [1:0] addr
    );
        if (size == `GMQ_SIZE_WORD) begin
            lanes = `GMQ_BE_ALL;
        end else if (size == `GMQ_SIZE_HALF) begin
            lanes = addr[1] ? `GMQ_BE_HI : `GMQ_BE_LO;
        end else begin
            lanes = `GMQ_BE_ONE << addr;
        end
    endfunction

    // address phase decode
    assign acc     = hsel && hready && htrans[1];
    assign acc_idx = haddr[`GMQ_IDX_W+1:2];
    assign acc_be  = lanes(hsize, haddr[1:0]);
    assign mapped  = (idx_r < `GMQ_NREG);

    // reads stall one cycle so a write just before is already visible
    assign hreadyout = !rd_wait_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            idx_r     <= '0;
            be_r      <= 4'h0;
        end else if (rd_wait_r) begin
            rd_wait_r <= 1'b0;
        end else begin
            wr_pend_r <= acc && hwrite;
            rd_wait_r <= acc && !hwrite;
            if (acc) begin
                idx_r <= acc_idx;
                be_r  <= acc_be;
            end
        end
    end

    // read value; data registers return the qualified pin levels
    always_comb begin
        rd_val = 32'h0;
        if (idx_r == `GMQ_DAT_A) begin
            rd_val = qual_in[`GMQ_NPIN_A-1:0];
        end else if (idx_r == `GMQ_DAT_B) begin
            rd_val = {29'h0, qual_in[`GMQ_NPIN-1:`GMQ_NPIN_A]};
        end else if (mapped) begin
            rd_val = cfg_r[idx_r] & reg_mask(idx_r);
        end
    end

    // read data capture at the end of the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (rd_wait_r) begin
            hrdata_r <= rd_val;
        end
    end

    assign be_bits = {{8{be_r[3]}}, {8{be_r[2]}}, {8{be_r[1]}}, {8{be_r[0]}}};
    assign wr_mask = be_bits & reg_mask(idx_r);

    // register writes, only enabled lanes and writable bits change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `GMQ_NREG; i++) begin
                cfg_r[i] <= `GMQ_RST_VAL;
            end
        end else if (wr_pend_r && mapped) begin
            cfg_r[idx_r] <= (cfg_r[idx_r] & ~wr_mask)
                          | (hwdata & wr_mask);
        end
    end

    // per-port fields flattened into per-pin vectors
    assign fsel_flat = {cfg_r[`GMQ_MUX_B1][5:0], cfg_r[`GMQ_MUX_A2],
                        cfg_r[`GMQ_MUX_A1]};
    assign qsel_flat = {cfg_r[`GMQ_QSEL_B1][5:0],
                        cfg_r[`GMQ_QSEL_A2], cfg_r[`GMQ_QSEL_A1]};
    assign dir_all   = {cfg_r[`GMQ_DIR_B][2:0], cfg_r[`GMQ_DIR_A]};
    assign dat_all   = {cfg_r[`GMQ_DAT_B][2:0], cfg_r[`GMQ_DAT_A]};

    // sample strobe divider per group of eight pins
    genvar g;
    generate
        for (g = 0; g < `GMQ_NGRP; g++) begin : grp
            if (g < `GMQ_NGRP - 1) begin : ga
                assign period[g] = cfg_r[`GMQ_CTRL_A][8*g +: 8];
            end else begin : gb
                assign period[g] = cfg_r[`GMQ_CTRL_B][7:0];
            end
            assign smp_stb[g] = (per_cnt_r[g] >= period[g]);
            // one strobe every period+1 clocks
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    per_cnt_r[g] <= 8'h00;
                end else if (smp_stb[g]) begin
                    per_cnt_r[g] <= 8'h00;
                end else begin
                    per_cnt_r[g] <= per_cnt_r[g] + 8'h01;
                end
            end
        end
    endgenerate

    // per-pin qualifier and output multiplexer
    genvar p;
    generate
        for (p = 0; p < `GMQ_NPIN; p++) begin : pin
            logic [1:0] qm;
            logic [1:0] fs;
            assign qm = (p < `GMQ_NPIN_A) ? qsel_flat[2*p +: 2]
                                          : qsel_flat[2*p +: 2];
            assign fs = fsel_flat[2*p +: 2];

            gmq_qual u_qual (
                .hclk    (hclk),
                .hresetn (hresetn),
                .pin_raw (pin_in[p]),
                .smp_stb (smp_stb[p / `GMQ_GRP_SIZE]),
                .mode    (gmq_pkg::gmq_qmode_t'(qm)),
                .q       (qual_in[p])
            );

            // function select steers level and enable
            always_comb begin
                case (gmq_pkg::gmq_func_t'(fs))
                    gmq_pkg::GMQ_F_PER1: begin
                        pin_out_nxt[p] = per1_out[p];
                        pin_oe_nxt[p]  = per1_oe[p];
                    end
                    gmq_pkg::GMQ_F_PER2: begin
                        pin_out_nxt[p] = per2_out[p];
                        pin_oe_nxt[p]  = per2_oe[p];
                    end
                    gmq_pkg::GMQ_F_PER3: begin
                        pin_out_nxt[p] = per3_out[p];
                        pin_oe_nxt[p]  = per3_oe[p];
                    end
                    default: begin
                        pin_out_nxt[p] = dat_all[p];
                        pin_oe_nxt[p]  = dir_all[p];
                    end
                endcase
            end
        end
    endgenerate

    // peripherals see the qualified level, bypass included
    assign per_in = qual_in;

    // registered pin drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out       <= '0;
            pin_oe        <= '0;
            pin_pullup_en <= '0;
        end else begin
            pin_out       <= pin_out_nxt;
            pin_oe        <= pin_oe_nxt;
            pin_pullup_en <= {cfg_r[`GMQ_PU_B][2:0],
                              cfg_r[`GMQ_PU_A]};
        end
    end

    // interrupt sources picked from port A qualified inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            external_interrupt_one         <= 1'b0;
            external_interrupt_two         <= 1'b0;
            external_nonmaskable_interrupt <= 1'b0;
        end else begin
            external_interrupt_one <=
                qual_in[cfg_r[`GMQ_INT1_SEL][4:0]];
            external_interrupt_two <=
                qual_in[cfg_r[`GMQ_INT2_SEL][4:0]];
            external_nonmaskable_interrupt <=
                qual_in[cfg_r[`GMQ_NMI_SEL][4:0]];
        end
    end

    // wake is taken after qualification, whatever the pin function
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= |(qual_in[`GMQ_NPIN_A-1:0]
                              & cfg_r[`GMQ_WAKE_SEL]);
        end
    end

    a_port_b_width: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg_r[`GMQ_DIR_B][31:3] == 29'h0 && cfg_r[`GMQ_MUX_B2] == 32'h0)
        else $error("port B holds bits beyond pin 34");

    a_half_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_r && idx_r == `GMQ_DIR_A && be_r == 4'hC)
        |=> cfg_r[`GMQ_DIR_A][15:0] == $past(cfg_r[`GMQ_DIR_A][15:0])
            && cfg_r[`GMQ_DIR_A][31:16] == $past(hwdata[31:16]))
        else $error("halfword write touched the wrong half");

    a_mux_gpio: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fsel_flat[1:0] == 2'h0) |=> pin_out[0] == $past(dat_all[0])
                                     && pin_oe[0] == $past(dir_all[0]))
        else $error("gpio function not driving pin 0");

    a_mux_periph: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fsel_flat[69:68] == 2'h2) |=> pin_out[34] == $past(per2_out[34]))
        else $error("peripheral two not routed to pin 34");

    // a period rewrite in flight excuses the spacing
    a_strobe_period: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (smp_stb[0] && period[0] == 8'h03)
        |=> (!smp_stb[0] || period[0] != 8'h03) [*3]
            ##1 (smp_stb[0] || period[0] != 8'h03))
        else $error("group zero strobe spacing wrong");

    a_int_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> external_interrupt_one
                 == $past(qual_in[cfg_r[`GMQ_INT1_SEL][4:0]]))
        else $error("interrupt one not following its source pin");

    a_wake_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (cfg_r[`GMQ_WAKE_SEL] == 32'h0) |=> !wake_request)
        else $error("wake raised with no source selected");

    a_pullup_follow: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(cfg_r[`GMQ_PU_A][5]) |=> pin_pullup_en[5])
        else $error("pull-up enable not applied");

    a_read_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (acc && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");

    a_wake_any: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (|(qual_in[`GMQ_NPIN_A-1:0] & cfg_r[`GMQ_WAKE_SEL]))
        |=> wake_request)
        else $error("selected pin high but no wake raised");

endmodule

// >>> hw/gmq_cfg.svh
`ifndef GMQ_CFG_SVH
`define GMQ_CFG_SVH

// pin counts
`define GMQ_NPIN        35
`define GMQ_NPIN_A      32
`define GMQ_NPIN_B      3
`define GMQ_NGRP        5
`define GMQ_GRP_SIZE    8

// register indices, byte address is index times four
`define GMQ_NREG        19
`define GMQ_IDX_W       5
`define GMQ_MUX_A1      5'h00
`define GMQ_MUX_A2      5'h01
`define GMQ_MUX_B1      5'h02
`define GMQ_MUX_B2      5'h03
`define GMQ_QSEL_A1     5'h04
`define GMQ_QSEL_A2     5'h05
`define GMQ_QSEL_B1     5'h06
`define GMQ_CTRL_A      5'h07
`define GMQ_CTRL_B      5'h08
`define GMQ_DIR_A       5'h09
`define GMQ_DIR_B       5'h0A
`define GMQ_PU_A        5'h0B
`define GMQ_PU_B        5'h0C
`define GMQ_DAT_A       5'h0D
`define GMQ_DAT_B       5'h0E
`define GMQ_INT1_SEL    5'h0F
`define GMQ_INT2_SEL    5'h10
`define GMQ_NMI_SEL     5'h11
`define GMQ_WAKE_SEL    5'h12

// writable bits of each register, the rest read as zero
`define GMQ_MASK_FULL   32'hFFFFFFFF
`define GMQ_MASK_SEL_B  32'h0000003F
`define GMQ_MASK_NONE   32'h00000000
`define GMQ_MASK_PER_B  32'h000000FF
`define GMQ_MASK_PIN_B  32'h00000007
`define GMQ_MASK_SRC    32'h0000001F
`define GMQ_RST_VAL     32'h00000000

// sampling window sizes
`define GMQ_WIN_SHORT   3'h3
`define GMQ_WIN_LONG    3'h6
`define GMQ_CNT_ONE     3'h1

// bus encodings
`define GMQ_SIZE_WORD   3'h2
`define GMQ_SIZE_HALF   3'h1
`define GMQ_BE_ALL      4'hF
`define GMQ_BE_HI       4'hC
`define GMQ_BE_LO       4'h3
`define GMQ_BE_ONE      4'h1

`endif

// >>> hw/gmq_pkg.sv
package gmq_pkg;

    // per-pin input qualification mode
    typedef enum logic [1:0] {
        GMQ_Q_SYNC  = 2'h0,
        GMQ_Q_WIN3  = 2'h1,
        GMQ_Q_WIN6  = 2'h2,
        GMQ_Q_ASYNC = 2'h3
    } gmq_qmode_t;

    // per-pin function select
    typedef enum logic [1:0] {
        GMQ_F_GPIO  = 2'h0,
        GMQ_F_PER1  = 2'h1,
        GMQ_F_PER2  = 2'h2,
        GMQ_F_PER3  = 2'h3
    } gmq_func_t;

endpackage

// >>> hw/gmq_qual.sv
`timescale 1ns/10ps
`include "gmq_cfg.svh"

module gmq_qual (
    // clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // pin and controls
    input  wire logic               pin_raw,
    input  wire logic               smp_stb,
    input  wire gmq_pkg::gmq_qmode_t mode,
    // qualified level
    output logic                    q
);

    logic       sync1_r;
    logic       sync2_r;
    logic       last_r;
    logic [2:0] cnt_r;
    logic       filt_r;
    logic [2:0] win;

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    assign win = (mode == gmq_pkg::GMQ_Q_WIN3) ? `GMQ_WIN_SHORT
                                               : `GMQ_WIN_LONG;

    // run of equal samples, restart on any differing sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_r <= 1'b0;
            cnt_r  <= 3'h0;
            filt_r <= 1'b0;
        end else if (smp_stb) begin
            if (sync2_r != last_r) begin
                last_r <= sync2_r;
                cnt_r  <= `GMQ_CNT_ONE;
            end else begin
                if (cnt_r < win) begin
                    cnt_r <= cnt_r + `GMQ_CNT_ONE;
                end
                if (cnt_r + `GMQ_CNT_ONE >= win) begin
                    filt_r <= sync2_r;
                end
            end
        end
    end

    // bypass skips the synchroniser, only meant for peripheral inputs
    always_comb begin
        case (mode)
            gmq_pkg::GMQ_Q_SYNC:  q = sync2_r;
            gmq_pkg::GMQ_Q_ASYNC: q = pin_raw;
            default:              q = filt_r;
        endcase
    end

    a_sync_path: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == gmq_pkg::GMQ_Q_SYNC) |-> q == $past(pin_raw, 2))
        else $error("sync mode output not two cycles behind pin");

    a_window_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (smp_stb && sync2_r != last_r) |=> filt_r == $past(filt_r))
        else $error("filter moved on a differing sample");

    a_window_take: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (smp_stb && sync2_r == last_r && cnt_r + 3'h1 >= win)
        |=> filt_r == $past(sync2_r))
        else $error("filter missed a full window");

endmodule

// >>> bench/gmq_pins.sv
`timescale 1ns/10ps
`include "gmq_cfg.svh"

// outside world: pads plus the three peripherals behind the mux
module gmq_pins #(
    parameter logic [34:0] P1O = 35'h0,
    parameter logic [34:0] P1E = 35'h0,
    parameter logic [34:0] P2O = 35'h0,
    parameter logic [34:0] P2E = 35'h0,
    parameter logic [34:0] P3O = 35'h0,
    parameter logic [34:0] P3E = 35'h0
) (
    // clock
    input  wire logic        hclk,
    // device pad side
    input  wire logic [34:0] pin_out,
    input  wire logic [34:0] pin_oe,
    input  wire logic [34:0] pin_pullup_en,
    output logic      [34:0] pin_in,
    // bench control of outside drive
    input  wire logic [34:0] ext_en,
    input  wire logic [34:0] ext_lvl,
    // peripheral drive
    output logic      [34:0] per1_out,
    output logic      [34:0] per1_oe,
    output logic      [34:0] per2_out,
    output logic      [34:0] per2_oe,
    output logic      [34:0] per3_out,
    output logic      [34:0] per3_oe
);
    logic        flt_r = 1'b0;
    logic [34:0] idle;

    // a floating pad wanders each cycle, so no stale level looks valid
    always @(posedge hclk) begin
        flt_r <= ~flt_r;
    end

    // device drive wins, then outside drive, then the pull-up
    assign idle   = pin_pullup_en | {35{flt_r}};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                  | (~pin_oe & ~ext_en & idle);

    // fixed patterns, distinct for each source
    assign per1_out = P1O;
    assign per1_oe  = P1E;
    assign per2_out = P2O;
    assign per2_oe  = P2E;
    assign per3_out = P3O;
    assign per3_oe  = P3E;
endmodule

// >>> bench/gmq_port_test.sv
`timescale 1ns/10ps
`include "gmq_cfg.svh"

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    mismatches++; $display("wrong value %s expected %h seen %h", nm, ex, \
    got); end end

module gmq_port_test;
    localparam logic [34:0] P1O = 35'h1_2345_6789;
    localparam logic [34:0] P1E = 35'h5_5555_5555;
    localparam logic [34:0] P2O = 35'h6_9ABC_DEF0;
    localparam logic [34:0] P2E = 35'h7_0F0F_0F0F;
    localparam logic [34:0] P3O = 35'h3_C3C3_C3C3;
    localparam logic [34:0] P3E = 35'h0_FFFF_0000;
    localparam logic [34:0] ON  = 35'h7_FFFF_FFFF;

    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [34:0] pin_in, pin_out, pin_oe, pin_pullup_en, per_in;
    logic [34:0] ext_en, ext_lvl, p1o, p1e, p2o, p2e, p3o, p3e;
    logic        irq1, irq2, nmi, wake;
    int          mismatches, tests_run;

    assign hready = hreadyout;

    gmq_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .per1_out(p1o), .per1_oe(p1e), .per2_out(p2o), .per2_oe(p2e),
        .per3_out(p3o), .per3_oe(p3e), .per_in(per_in),
        .external_interrupt_one(irq1), .external_interrupt_two(irq2),
        .external_nonmaskable_interrupt(nmi), .wake_request(wake));

    gmq_pins #(.P1O(P1O), .P1E(P1E), .P2O(P2O), .P2E(P2E), .P3O(P3O),
        .P3E(P3E)) u_pins (.hclk(hclk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_in(pin_in),
        .ext_en(ext_en), .ext_lvl(ext_lvl), .per1_out(p1o),
        .per1_oe(p1e), .per2_out(p2o), .per2_oe(p2e), .per3_out(p3o),
        .per3_oe(p3e));

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ready is taken at the rising edge, as the slave sees it
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                mismatches++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [4:0] idx,
                       input logic [1:0] off, input logic [2:0] sz,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {25'h0, idx, off};
        hwrite <= w;
        hsize  <= sz;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        bus(1'b1, idx, 2'h0, `GMQ_SIZE_WORD, d);
    endtask

    task automatic rdchk(input logic [4:0] idx, input logic [31:0] ex);
        bus(1'b0, idx, 2'h0, `GMQ_SIZE_WORD, 32'h0);
        `CHK("hrdata", ex, rd);
        `CHK("hresp", 1'b0, hresp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic drive(input logic [34:0] lvl);
        @(posedge hclk);
        ext_lvl <= lvl;
    endtask

    task automatic t_reset();
        rdchk(`GMQ_QSEL_A1, 32'h0);
        rdchk(`GMQ_QSEL_B1, 32'h0);
        wr(5'h15, 32'hFFFF_FFFF);
        rdchk(5'h15, 32'h0);
        `CHK("pin_oe", 35'h0, pin_oe);
    endtask

    task automatic t_ports();
        bus(1'b1, `GMQ_DIR_A, 2'h2, `GMQ_SIZE_HALF, 32'h8421_0000);
        bus(1'b1, `GMQ_DIR_A, 2'h0, `GMQ_SIZE_HALF, 32'h0000_1248);
        rdchk(`GMQ_DIR_A, 32'h8421_1248);
        bus(1'b0, `GMQ_DIR_A, 2'h2, `GMQ_SIZE_HALF, 32'h0);
        `CHK("half read", 16'h8421, rd[31:16]);
        wr(`GMQ_DIR_B, 32'hFFFF_FFFF);
        rdchk(`GMQ_DIR_B, 32'h7);
        wr(`GMQ_DAT_A, 32'h8000_0001);
        wr(`GMQ_DAT_B, 32'h4);
        settle(2);
        `CHK("pin_oe", 35'h7_8421_1248, pin_oe);
        `CHK("pin_out", 35'h4_8000_0000, pin_out & pin_oe);
        rdchk(`GMQ_DAT_B, 32'h4);
        wr(`GMQ_DIR_A, 32'h0);
        wr(`GMQ_DIR_B, 32'h0);
    endtask

    task automatic t_mux();
        logic [1:0]  f;
        logic [34:0] eo, ee;
        for (int k = 0; k < 4; k++) begin
            f  = k[1:0];
            eo = (k == 1) ? P1O : (k == 2) ? P2O : P3O;
            ee = (k == 1) ? P1E : (k == 2) ? P2E : (k == 3) ? P3E : 35'h0;
            wr(`GMQ_MUX_A1, {16{f}});
            wr(`GMQ_MUX_A2, {16{f}});
            wr(`GMQ_MUX_B1, {26'h0, {3{f}}});
            settle(2);
            `CHK("pin_oe", ee, pin_oe);
            `CHK("pin_out", eo & ee, pin_out & pin_oe);
        end
        rdchk(`GMQ_MUX_A2, 32'hFFFF_FFFF);
        rdchk(`GMQ_MUX_B2, 32'h0);
        wr(`GMQ_MUX_A1, 32'h0);
        wr(`GMQ_MUX_A2, 32'h0);
        wr(`GMQ_MUX_B1, 32'h0);
    endtask

    task automatic t_pull();
        wr(`GMQ_PU_A, 32'hA5A5_0F0F);
        wr(`GMQ_PU_B, 32'h5);
        settle(2);
        `CHK("pullup", 35'h5_A5A5_0F0F, pin_pullup_en);
        @(posedge hclk);
        ext_en[0] <= 1'b0;
        settle(3);
        `CHK("released pad", 1'b1, per_in[0]);
        @(negedge hclk);
        `CHK("released pad", 1'b1, per_in[0]);
        @(posedge hclk);
        ext_en[0] <= 1'b1;
        wr(`GMQ_PU_A, 32'h0);
        wr(`GMQ_PU_B, 32'h0);
    endtask

    // two flops in sync mode: old level after one edge, new after two
    task automatic t_sync();
        drive(35'h10);
        settle(1);
        `CHK("sync early", 1'b0, per_in[4]);
        @(negedge hclk);
        `CHK("sync", 1'b1, per_in[4]);
        rdchk(`GMQ_DAT_A, 32'h10);
        drive(35'h0);
    endtask

    // group 0 samples every 4 clocks, group 1 every clock
    task automatic t_window();
        wr(`GMQ_CTRL_A, 32'h0000_0003);
        wr(`GMQ_QSEL_A1, 32'h0001_0009);
        rdchk(`GMQ_CTRL_A, 32'h3);
        settle(40);
        drive(35'h103);
        settle(7);
        `CHK("groups", 3'b100, {per_in[8], per_in[1:0]});
        settle(13);
        `CHK("window 3", 2'b01, per_in[1:0]);
        settle(20);
        `CHK("window 6", 1'b1, per_in[1]);
        drive(35'h101);
        settle(7);
        `CHK("dip hold", 1'b1, per_in[1]);
        drive(35'h103);
        settle(30);
        `CHK("short dip", 1'b1, per_in[1]);
        drive(35'h0);
        wr(`GMQ_QSEL_A1, 32'h0);
        wr(`GMQ_CTRL_A, 32'h0);
    endtask

    task automatic t_bypass();
        wr(`GMQ_MUX_A1, 32'h0004_0000);
        wr(`GMQ_QSEL_A1, 32'h000C_0000);
        drive(35'h200);
        #1;
        `CHK("bypass", 1'b1, per_in[9]);
        drive(35'h0);
        wr(`GMQ_QSEL_A1, 32'h0);
        wr(`GMQ_MUX_A1, 32'h0);
    endtask

    task automatic t_irq();
        logic [4:0] src [3];
        src = '{5'h1F, 5'h00, 5'h11};
        wr(`GMQ_INT1_SEL, 32'h1F);
        wr(`GMQ_INT2_SEL, 32'h0);
        wr(`GMQ_NMI_SEL, 32'h11);
        for (int k = 0; k < 3; k++) begin
            drive(35'h1 << src[k]);
            settle(4);
            `CHK("sources", 3'b001 << k, {nmi, irq2, irq1});
        end
        drive(35'h0);
    endtask

    // pin 3 plain input, pin 7 on peripheral one, pin 9 not chosen
    task automatic t_wake();
        logic [34:0] lv [4];
        logic        ex [4];
        lv = '{35'h8, 35'h80, 35'h200, 35'h0};
        ex = '{1'b1, 1'b1, 1'b0, 1'b0};
        wr(`GMQ_MUX_A1, 32'h0000_4000);
        wr(`GMQ_WAKE_SEL, 32'h0000_0088);
        for (int k = 0; k < 4; k++) begin
            drive(lv[k]);
            settle(4);
            `CHK("wake", ex[k], wake);
        end
    endtask

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        ext_en     = ON;
        ext_lvl    = 35'h0;
        mismatches = 0;
        tests_run  = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_ports();
        t_mux();
        t_pull();
        t_sync();
        t_window();
        t_bypass();
        t_irq();
        t_wake();
        conclude();
    end
endmodule
